//--- rtl/pfc_defines.svh
// pad function configuration: register offsets, field positions, reset values, timing
// assumes a 100 MHz system clock and word-aligned register offsets
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH

// ==========================================================
// register offsets (byte addresses)
`define PFC_ADDR_W 12
`define PFC_OFF_PAD2 12'h008
`define PFC_OFF_PAD3 12'h00C
`define PFC_OFF_PAD4 12'h010
`define PFC_OFF_PAD5 12'h014
`define PFC_OFF_PAD9 12'h024
`define PFC_OFF_PAD10 12'h028
`define PFC_OFF_PAD11 12'h02C
`define PFC_OFF_PAD13 12'h034
`define PFC_OFF_PAD15 12'h03C
`define PFC_OFF_PAD16 12'h040
`define PFC_OFF_PAD22 12'h058

// ==========================================================
// pad counts and stored width
`define PFC_NPAD 11
`define PFC_NOD 2
`define PFC_CFG_W 11

// ==========================================================
// field positions
`define PFC_B_FUNCTION_SELECT 2
`define PFC_B_MODE 3
`define PFC_B_SCHMITT 5
`define PFC_B_INV 6
`define PFC_B_ANALOG_DIGITAL_SELECT 7
`define PFC_B_FILT 8
`define PFC_B_SLEW 9
`define PFC_B_OD 10
`define PFC_B_HS 8
`define PFC_B_HISINK 9

// ==========================================================
// reset values and writable masks
`define PFC_RST_OD 11'h180
`define PFC_RST_AN 11'h190
`define PFC_MASK_OD 11'h307
`define PFC_MASK_AN 11'h7FF
`define PFC_RESERVED_OD 5'h10

// ==========================================================
// timing
`define PFC_CLK_NS 10
`define PFC_FILT_AN_NS 10
`define PFC_FILT_OD_NS 50
// a glitch of the filter time spans that many samples, so one more is needed to pass
`define PFC_FILT_AN_CYC (`PFC_FILT_AN_NS / `PFC_CLK_NS + 1)
`define PFC_FILT_OD_CYC (`PFC_FILT_OD_NS / `PFC_CLK_NS + 1)

// ==========================================================
// bus responses
`define PFC_RESP_OKAY 2'h0
`define PFC_RESP_SLVERR 2'h2

`endif

//--- rtl/pfc_pkg.sv
// pad function configuration: shared types
// assumes pfc_defines.svh for the pad count

`include "pfc_defines.svh"

package pfc_pkg;

	// ==========================================================
	// pad functions
	typedef enum logic [4:0] {
		FN_GPIO, FN_SCL, FN_SDA, FN_SWCLK, FN_SWDIO, FN_T16_CAP0, FN_T16_CAP1,
		FN_T16_MAT1, FN_T16_MAT2, FN_T32_CAP0, FN_T32_CAP2, FN_T32_MAT1, FN_ANALOG_OUT,
		FN_MOSI, FN_SCK, FN_MISO, FN_CTS, FN_RTS, FN_SCLK, FN_TXD, FN_TRIG, FN_NONE
	} pfc_fn_t;

	// ==========================================================
	// peripheral drive toward pads
	typedef struct packed {
		logic [`PFC_NPAD-1:0] gpio_out;
		logic [`PFC_NPAD-1:0] gpio_oe;
		logic scl_out;
		logic sda_out;
		logic swdio_out;
		logic swdio_oe;
		logic t16_match1;
		logic t16_match2;
		logic t32_match1;
		logic mosi_out;
		logic mosi_oe;
		logic sck_out;
		logic sck_oe;
		logic miso_out;
		logic miso_oe;
		logic txd;
		logic rts;
		logic sclk_out;
		logic sclk_oe;
	} pfc_periph_out_t;

	// ==========================================================
	// pad values toward peripherals
	typedef struct packed {
		logic [`PFC_NPAD-1:0] gpio_in;
		logic scl_in;
		logic sda_in;
		logic swclk;
		logic swdio_in;
		logic t16_capture0;
		logic t16_capture1;
		logic t32_capture0;
		logic t32_capture2;
		logic mosi_in;
		logic sck_in;
		logic miso_in;
		logic cts;
		logic sclk_in;
		logic analog_trigger;
	} pfc_periph_in_t;

	// ==========================================================
	// electrical pad controls
	typedef struct packed {
		logic pull_up;
		logic pull_down;
		logic repeater;
		logic schmitt;
		logic analog_en;
		logic slew_fast;
		logic high_sink;
		logic i2c_features_en;
	} pfc_pad_ctrl_t;

endpackage

//--- rtl/pfc_pad_filter.sv
// pad input synchroniser and glitch filter
// assumes an asynchronous pad level on pad_in and a synchronous active-high reset

`timescale 1ns/1ps
`default_nettype none

module pfc_pad_filter #(
	parameter int STABLE = 1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// pad side
	input wire logic pad_in,
	input wire logic bypass,
	// filtered level
	output logic level
);

	logic sync_a;
	logic sync_b;
	logic [7:0] cnt;

	if (STABLE < 1 || STABLE > 255) begin : g_chk
		$error("pfc_pad_filter: STABLE out of range");
	end

	// ==========================================================
	// two-stage synchroniser
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end else begin
			sync_a <= pad_in;
			sync_b <= sync_a;
		end
	end

	// ==========================================================
	// level follows at once when bypass is set, else only after STABLE cycles of a new value
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			level <= 1'b0;
			cnt <= 8'h00;
		end else if (bypass || sync_b == level) begin
			level <= sync_b;
			cnt <= 8'h00;
		end else if (cnt == 8'(STABLE - 1)) begin
			level <= sync_b;
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end

	chk_filter_hold: assert property (@(posedge sys_clk) disable iff (rst)
		(!bypass && $past(!bypass) && level != $past(level)) |-> $past(cnt) == 8'(STABLE - 1))
		else $error("filtered level changed before the stable time");

endmodule
`default_nettype wire

//--- rtl/pfc_top.sv
// pad function configuration: AXI4-Lite register file, function routing, pad drive
// assumes pads resolve pad_out/pad_oe externally and pad_in is asynchronous
// Summary of operation
// - all function pads of the general port pass through this multiplexer
// - each pad's function comes only from its own selector field
// - open-drain pads use selector bits 2:0 and never drive high
// - pad2: gpio, SCL, SWCLK, t16 capture0; pad3: gpio, SDA, SWDIO; reset zero
// - open-drain bit 8 set bypasses I2C filter and slew; resets to 1
// - pads 4, 5, 9, 10, 11 decode timers, SSP, USART, debug, analog out
// - pads 13, 15, 16, 22 decode USART, timers, I2C, trigger, MISO; reset zero
// - analog pad bits 4:3 pick none, pull-down, pull-up or repeater; reset pull-up
// - analog pad bit 6 inverts the sampled input
// - analog pad bit 7 clear is analog mode, set is digital; reset digital
// - analog pad bit 8 clear filters glitches, set bypasses; reset bypass
// - analog pad bit 10 set drives low only

`timescale 1ns/1ps
`default_nettype none
`include "pfc_defines.svh"

module pfc_top #(
	parameter int NPAD = `PFC_NPAD
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// axi4-lite write
	input wire logic [`PFC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [`PFC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// peripherals
	input wire pfc_pkg::pfc_periph_out_t periph_out,
	output pfc_pkg::pfc_periph_in_t periph_in,
	// pads
	input wire logic [NPAD-1:0] pad_in,
	output logic [NPAD-1:0] pad_out,
	output logic [NPAD-1:0] pad_oe,
	output pfc_pkg::pfc_pad_ctrl_t [NPAD-1:0] pad_ctrl
);
	import pfc_pkg::*;

	if (NPAD != `PFC_NPAD) begin : g_chk
		$error("pfc_top: NPAD must match the fixed pad list");
	end

	localparam logic [4:0] NO_PAD = 5'h1F;

	logic [`PFC_CFG_W-1:0] cfg [NPAD];
	pfc_fn_t fn [NPAD];
	logic [NPAD-1:0] filt;
	logic [NPAD-1:0] din;
	logic [NPAD-1:0] next_pad_out;
	logic [NPAD-1:0] next_pad_oe;
	logic aw_held;
	logic w_held;
	logic [`PFC_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic [4:0] wr_idx;
	logic [4:0] rd_idx;

	// ==========================================================
	// address decode
	function automatic logic [4:0] pad_index(input logic [`PFC_ADDR_W-1:0] a);
		if (a == `PFC_OFF_PAD2) pad_index = 5'h00;
		else if (a == `PFC_OFF_PAD3) pad_index = 5'h01;
		else if (a == `PFC_OFF_PAD4) pad_index = 5'h02;
		else if (a == `PFC_OFF_PAD5) pad_index = 5'h03;
		else if (a == `PFC_OFF_PAD9) pad_index = 5'h04;
		else if (a == `PFC_OFF_PAD10) pad_index = 5'h05;
		else if (a == `PFC_OFF_PAD11) pad_index = 5'h06;
		else if (a == `PFC_OFF_PAD13) pad_index = 5'h07;
		else if (a == `PFC_OFF_PAD15) pad_index = 5'h08;
		else if (a == `PFC_OFF_PAD16) pad_index = 5'h09;
		else if (a == `PFC_OFF_PAD22) pad_index = 5'h0A;
		else pad_index = NO_PAD;
	endfunction

	// ==========================================================
	// selector decode per pad
	function automatic pfc_fn_t decode_fn(input int idx, input logic [2:0] f);
		decode_fn = FN_NONE;
		case (idx)
			0: case (f)
				3'h0: decode_fn = FN_GPIO;
				3'h1: decode_fn = FN_SCL;
				3'h3: decode_fn = FN_SWCLK;
				3'h4: decode_fn = FN_T16_CAP0;
				default: decode_fn = FN_NONE;
			endcase
			1: case (f)
				3'h0: decode_fn = FN_GPIO;
				3'h1: decode_fn = FN_SDA;
				3'h3: decode_fn = FN_SWDIO;
				default: decode_fn = FN_NONE;
			endcase
			2: case (f)
				3'h0: decode_fn = FN_GPIO;
				3'h2: decode_fn = FN_ANALOG_OUT;
				3'h3: decode_fn = FN_T16_MAT1;
				3'h4: decode_fn = FN_MOSI;
				default: decode_fn = FN_NONE;
			endcase
			3: case (f)
				3'h0: decode_fn = FN_SWCLK;
				3'h1: decode_fn = FN_GPIO;
				3'h3: decode_fn = FN_T16_MAT2;
				3'h4: decode_fn = FN_SCK;
				default: decode_fn = FN_NONE;
			endcase
			4: case (f)
				3'h1: decode_fn = FN_GPIO;
				3'h4: decode_fn = FN_T16_MAT1;
				3'h5: decode_fn = FN_CTS;
				default: decode_fn = FN_NONE;
			endcase
			5: case (f)
				3'h0: decode_fn = FN_SWDIO;
				3'h1: decode_fn = FN_GPIO;
				3'h4: decode_fn = FN_T16_MAT2;
				3'h5: decode_fn = FN_RTS;
				default: decode_fn = FN_NONE;
			endcase
			6: case (f)
				3'h0: decode_fn = FN_GPIO;
				3'h1: decode_fn = FN_SCLK;
				3'h4: decode_fn = FN_T32_CAP0;
				default: decode_fn = FN_NONE;
			endcase
			7: case (f)
				3'h0: decode_fn = FN_GPIO;
				3'h1: decode_fn = FN_TXD;
				3'h3: decode_fn = FN_T32_MAT1;
				3'h4: decode_fn = FN_SDA;
				default: decode_fn = FN_NONE;
			endcase
			8: case (f)
				3'h0: decode_fn = FN_GPIO;
				3'h1: decode_fn = FN_TXD;
				3'h3: decode_fn = FN_T32_CAP2;
				3'h4: decode_fn = FN_SDA;
				default: decode_fn = FN_NONE;
			endcase
			9: case (f)
				3'h0: decode_fn = FN_GPIO;
				3'h1: decode_fn = FN_TRIG;
				3'h3: decode_fn = FN_T16_CAP1;
				3'h4: decode_fn = FN_SCL;
				default: decode_fn = FN_NONE;
			endcase
			10: case (f)
				3'h0: decode_fn = FN_GPIO;
				3'h1: decode_fn = FN_MISO;
				default: decode_fn = FN_NONE;
			endcase
			default: decode_fn = FN_NONE;
		endcase
	endfunction

	// ==========================================================
	// axi4-lite write channel
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign wr_idx = pad_index(aw_addr);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PFC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_idx == NO_PAD) ? `PFC_RESP_SLVERR : `PFC_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// configuration registers
	for (genvar i = 0; i < NPAD; i++) begin : g_cfg
		localparam logic [`PFC_CFG_W-1:0] RST = (i < `PFC_NOD) ? `PFC_RST_OD : `PFC_RST_AN;
		localparam logic [`PFC_CFG_W-1:0] MSK = (i < `PFC_NOD) ? `PFC_MASK_OD : `PFC_MASK_AN;
		logic [`PFC_CFG_W-1:0] merged;
		always_comb begin
			merged[7:0] = w_strb[0] ? w_data[7:0] : cfg[i][7:0];
			merged[10:8] = w_strb[1] ? w_data[10:8] : cfg[i][10:8];
		end
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				cfg[i] <= RST;
			end else if (wr_fire && wr_idx == 5'(i)) begin
				cfg[i] <= (merged & MSK) | (RST & ~MSK);
			end
		end
	end

	// ==========================================================
	// axi4-lite read channel
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_idx = pad_index(s_axi_araddr);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `PFC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			if (rd_idx == NO_PAD) begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `PFC_RESP_SLVERR;
			end else begin
				s_axi_rdata <= {21'h000000, cfg[rd_idx[3:0]]};
				s_axi_rresp <= `PFC_RESP_OKAY;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// input path: sync, filter, polarity, analog gating
	for (genvar i = 0; i < NPAD; i++) begin : g_in
		localparam bit IS_OD = (i < `PFC_NOD);
		pfc_pad_filter #(
			.STABLE(IS_OD ? `PFC_FILT_OD_CYC : `PFC_FILT_AN_CYC)
		) u_filt (
			.sys_clk(sys_clk),
			.rst(rst),
			.pad_in(pad_in[i]),
			.bypass(cfg[i][IS_OD ? `PFC_B_HS : `PFC_B_FILT]),
			.level(filt[i])
		);
		if (IS_OD) begin : g_od
			assign din[i] = filt[i];
			assign pad_ctrl[i] = '{pull_up: 1'b0, pull_down: 1'b0, repeater: 1'b0, schmitt: 1'b0,
				analog_en: 1'b0, slew_fast: cfg[i][`PFC_B_HS], high_sink: cfg[i][`PFC_B_HISINK],
				i2c_features_en: !cfg[i][`PFC_B_HS]};
		end else begin : g_an
			assign din[i] = cfg[i][`PFC_B_ANALOG_DIGITAL_SELECT] && (filt[i] ^ cfg[i][`PFC_B_INV]);
			assign pad_ctrl[i] = '{pull_up: cfg[i][4:3] == 2'b10, pull_down: cfg[i][4:3] == 2'b01,
				repeater: cfg[i][4:3] == 2'b11, schmitt: cfg[i][`PFC_B_SCHMITT],
				analog_en: !cfg[i][`PFC_B_ANALOG_DIGITAL_SELECT], slew_fast: cfg[i][`PFC_B_SLEW],
				high_sink: 1'b0, i2c_features_en: 1'b0};
		end
	end

	// ==========================================================
	// peripheral inputs: lowest selected pad wins, else inactive default
	always_comb begin
		periph_in = '0;
		periph_in.scl_in = 1'b1;
		periph_in.sda_in = 1'b1;
		periph_in.cts = 1'b1;
		for (int i = NPAD - 1; i >= 0; i--) begin
			fn[i] = decode_fn(i, cfg[i][`PFC_B_FUNCTION_SELECT:0]);
			case (fn[i])
				FN_SCL: periph_in.scl_in = din[i];
				FN_SDA: periph_in.sda_in = din[i];
				FN_SWCLK: periph_in.swclk = din[i];
				FN_SWDIO: periph_in.swdio_in = din[i];
				FN_T16_CAP0: periph_in.t16_capture0 = din[i];
				FN_T16_CAP1: periph_in.t16_capture1 = din[i];
				FN_T32_CAP0: periph_in.t32_capture0 = din[i];
				FN_T32_CAP2: periph_in.t32_capture2 = din[i];
				FN_MOSI: periph_in.mosi_in = din[i];
				FN_SCK: periph_in.sck_in = din[i];
				FN_MISO: periph_in.miso_in = din[i];
				FN_CTS: periph_in.cts = din[i];
				FN_SCLK: periph_in.sclk_in = din[i];
				FN_TRIG: periph_in.analog_trigger = din[i];
				default: ;
			endcase
		end
		periph_in.gpio_in = din;
	end

	// ==========================================================
	// output path: function select, open-drain conversion
	always_comb begin
		logic v;
		logic e;
		logic drain;
		v = 1'b0;
		e = 1'b0;
		drain = 1'b0;
		next_pad_out = '0;
		next_pad_oe = '0;
		for (int i = 0; i < NPAD; i++) begin
			drain = 1'b0;
			case (fn[i])
				FN_GPIO: begin v = periph_out.gpio_out[i]; e = periph_out.gpio_oe[i]; end
				FN_SCL: begin v = periph_out.scl_out; e = 1'b1; drain = 1'b1; end
				FN_SDA: begin v = periph_out.sda_out; e = 1'b1; drain = 1'b1; end
				FN_SWDIO: begin v = periph_out.swdio_out; e = periph_out.swdio_oe; end
				FN_T16_MAT1: begin v = periph_out.t16_match1; e = 1'b1; end
				FN_T16_MAT2: begin v = periph_out.t16_match2; e = 1'b1; end
				FN_T32_MAT1: begin v = periph_out.t32_match1; e = 1'b1; end
				FN_MOSI: begin v = periph_out.mosi_out; e = periph_out.mosi_oe; end
				FN_SCK: begin v = periph_out.sck_out; e = periph_out.sck_oe; end
				FN_MISO: begin v = periph_out.miso_out; e = periph_out.miso_oe; end
				FN_TXD: begin v = periph_out.txd; e = 1'b1; end
				FN_RTS: begin v = periph_out.rts; e = 1'b1; end
				FN_SCLK: begin v = periph_out.sclk_out; e = periph_out.sclk_oe; end
				default: begin v = 1'b0; e = 1'b0; end
			endcase
			if (i < `PFC_NOD) begin
				drain = 1'b1;
			end else begin
				drain = drain || cfg[i][`PFC_B_OD];
				e = e && cfg[i][`PFC_B_ANALOG_DIGITAL_SELECT];
			end
			next_pad_out[i] = drain ? 1'b0 : v;
			next_pad_oe[i] = drain ? (e && !v) : e;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pad_out <= '0;
			pad_oe <= '0;
		end else begin
			pad_out <= next_pad_out;
			pad_oe <= next_pad_oe;
		end
	end

	// ==========================================================
	// checks
	chk_od_low_only: assert property (@(posedge sys_clk) disable iff (rst)
		!(pad_out[0] || pad_out[1])) else $error("open-drain pad driven high");
	chk_function_select_reset: assert property (@(posedge sys_clk)
		rst |=> (fn[0] == FN_GPIO && fn[3] == FN_SWCLK && fn[10] == FN_GPIO))
		else $error("selector not zero after reset");
	chk_hs_write: assert property (@(posedge sys_clk) disable iff (rst)
		(wr_fire && wr_idx == 5'h00 && w_strb[1]) |=> pad_ctrl[0].i2c_features_en == !$past(w_data[8]))
		else $error("fast-mode bypass write not applied");
	chk_pull_reset: assert property (@(posedge sys_clk)
		rst |=> (pad_ctrl[2].pull_up && !pad_ctrl[2].repeater && !pad_ctrl[0].pull_up))
		else $error("pull mode reset wrong");
	chk_input_invert: assert property (@(posedge sys_clk) disable iff (rst)
		(cfg[9][`PFC_B_INV] && cfg[9][`PFC_B_ANALOG_DIGITAL_SELECT]) |-> periph_in.gpio_in[9] == !filt[9])
		else $error("input polarity not applied");
	chk_analog_quiet: assert property (@(posedge sys_clk) disable iff (rst)
		(!cfg[10][`PFC_B_ANALOG_DIGITAL_SELECT] ##1 !cfg[10][`PFC_B_ANALOG_DIGITAL_SELECT]) |-> !pad_oe[10] && !periph_in.gpio_in[10])
		else $error("analog pad still digital");
	chk_od_mode: assert property (@(posedge sys_clk) disable iff (rst)
		(cfg[2][`PFC_B_OD] ##1 cfg[2][`PFC_B_OD]) |-> !pad_out[2]) else $error("od pad drove high");
	chk_reserved_read: assert property (@(posedge sys_clk) disable iff (rst)
		(s_axi_arvalid && s_axi_arready && rd_idx == 5'h01) |=>
		(s_axi_rdata[7:3] == `PFC_RESERVED_OD && s_axi_rdata[31:10] == 22'h0))
		else $error("reserved bits read wrong");
	chk_route_default: assert property (@(posedge sys_clk) disable iff (rst)
		(fn[0] != FN_SCL && fn[9] != FN_SCL) |-> periph_in.scl_in) else $error("scl input not idle");
	chk_function_select_route: assert property (@(posedge sys_clk) disable iff (rst)
		(fn[4] == FN_T16_MAT1 && !cfg[4][`PFC_B_OD] && cfg[4][`PFC_B_ANALOG_DIGITAL_SELECT]) |=>
		(pad_out[4] == $past(periph_out.t16_match1) && pad_oe[4])) else $error("match not routed");
	cov_write: cover property (@(posedge sys_clk) disable iff (rst) wr_fire && wr_idx != NO_PAD);
	cov_bad_read: cover property (@(posedge sys_clk) disable iff (rst) s_axi_rvalid && s_axi_rresp != 2'h0);
	cov_i2c_pad16: cover property (@(posedge sys_clk) disable iff (rst) fn[9] == FN_SCL);
	cov_od_sink: cover property (@(posedge sys_clk) disable iff (rst) pad_oe[1] && fn[1] == FN_SDA);

endmodule
`default_nettype wire

//--- testbench/test_pad_function_config.sv
// testbench for the pad function configuration block
// assumes the rtl package and pfc_top are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defines.svh"
module test_pad_function_config;
	import pfc_pkg::*;
	// ==========================================================
	// signals
	logic sys_clk = 0;
	logic rst = 1;
	logic [11:0] awaddr = 0;
	logic [11:0] araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rd;
	pfc_periph_out_t po = '0;
	pfc_periph_in_t pi;
	logic [10:0] pin = 11'h7FF;
	logic [10:0] pout, poe;
	pfc_pad_ctrl_t [10:0] pctl;
	logic [31:0] lfsr = 32'h885778DA;
	logic low;
	logic [11:0] offs [11] = '{`PFC_OFF_PAD2, `PFC_OFF_PAD3, `PFC_OFF_PAD4, `PFC_OFF_PAD5, `PFC_OFF_PAD9,
		`PFC_OFF_PAD10, `PFC_OFF_PAD11, `PFC_OFF_PAD13, `PFC_OFF_PAD15, `PFC_OFF_PAD16, `PFC_OFF_PAD22};
	int bad_count = 0;
	int checked = 0;
	pfc_top u_pfc_top (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .periph_out(po),
		.periph_in(pi), .pad_in(pin), .pad_out(pout), .pad_oe(poe), .pad_ctrl(pctl));
	always #5 sys_clk = ~sys_clk;
	// ==========================================================
	// helpers
	function automatic logic [31:0] lfsr_step(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [31:0] exp_cfg(input bit od, input logic [31:0] d);
		return od ? ((d & 32'h0000_0307) | 32'h0000_0080) : (d & 32'h0000_07FF);
	endfunction
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (awready === 1'b1) awvalid <= 0;
			if (wready === 1'b1) wvalid <= 0;
			if (bvalid === 1'b1) break;
		end
		rs = bresp;
		bready <= 0;
		if (n == 50) begin
			bad_count++;
			wrap_up();
		end
	endtask
	task automatic axi_rd(input logic [11:0] a);
		int n;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (arready === 1'b1) arvalid <= 0;
			if (rvalid === 1'b1) break;
		end
		rd = rdata;
		rs = rresp;
		rready <= 0;
		if (n == 50) begin
			bad_count++;
			wrap_up();
		end
	endtask
	task automatic glitch(input int p, input int w, output logic seen_low);
		seen_low = 0;
		pin[p] <= 0;
		repeat (w) @(posedge sys_clk);
		pin[p] <= 1;
		repeat (12) begin
			@(posedge sys_clk);
			if (pi.gpio_in[p] === 1'b0) seen_low = 1;
		end
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 0;
		repeat (4) @(posedge sys_clk);
		chk("swclk reset", pi.swclk, 1);
		chk("pull reset", {pctl[2].pull_up, pctl[2].pull_down}, 2'h2);
		for (int i = 0; i < 11; i++) begin
			axi_rd(offs[i]);
			chk("reset value", rd, (i < 2) ? 32'h180 : 32'h190);
			chk("read resp", rs, `PFC_RESP_OKAY);
		end
		// reserved bits set, selectors kept at a defined value
		axi_wr(`PFC_OFF_PAD3, 32'hFFFFFFF8);
		axi_rd(`PFC_OFF_PAD3);
		chk("od reserved", rd, exp_cfg(1, 32'hFFFFFFF8));
		axi_wr(`PFC_OFF_PAD22, 32'hFFFFFFF8);
		axi_rd(`PFC_OFF_PAD22);
		chk("an reserved", rd, exp_cfg(0, 32'hFFFFFFF8));
		axi_wr(12'h030, 32'h1);
		chk("unmapped wr", rs, `PFC_RESP_SLVERR);
		axi_rd(12'h030);
		chk("unmapped rd", rd, 32'h0);
		chk("unmapped resp", rs, `PFC_RESP_SLVERR);
		// function selection, all values defined for their pads
		axi_wr(`PFC_OFF_PAD2, 32'h101);
		axi_wr(`PFC_OFF_PAD9, 32'h194);
		axi_wr(`PFC_OFF_PAD13, 32'h191);
		axi_wr(`PFC_OFF_PAD11, 32'h194);
		axi_wr(`PFC_OFF_PAD16, 32'h1D1);
		axi_wr(`PFC_OFF_PAD4, 32'h590);
		axi_wr(`PFC_OFF_PAD10, 32'h191);
		axi_wr(`PFC_OFF_PAD22, 32'h110);
		for (int k = 0; k < 12; k++) begin
			lfsr = lfsr_step(lfsr);
			po <= {lfsr, lfsr[6:0]};
			pin <= lfsr[10:0] ^ lfsr[21:11];
			repeat (6) @(posedge sys_clk);
			chk("scl oe", poe[0], !po.scl_out);
			chk("scl out", pout[0], 0);
			chk("scl in", pi.scl_in, pin[0]);
			chk("mat1 pad9", {poe[4], pout[4]}, {1'b1, po.t16_match1});
			chk("txd pad13", {poe[7], pout[7]}, {1'b1, po.txd});
			chk("cap0 pad11", pi.t32_capture0, pin[6]);
			chk("trig inv", pi.analog_trigger, !pin[9]);
			chk("drain oe", poe[2], po.gpio_oe[2] & !po.gpio_out[2]);
			chk("drain hi", pout[2] & poe[2], 0);
			chk("analog oe", {poe[10], pctl[10].analog_en, pi.gpio_in[10]}, 3'h2);
			chk("idle inputs", {pi.swdio_in, pi.cts}, 2'h1);
		end
		axi_wr(`PFC_OFF_PAD2, 32'h104);
		repeat (6) @(posedge sys_clk);
		chk("cap0 pad2", pi.t16_capture0, pin[0]);
		axi_wr(`PFC_OFF_PAD2, 32'h103);
		repeat (6) @(posedge sys_clk);
		chk("swclk pad2", pi.swclk, pin[0]);
		for (int m = 0; m < 4; m++) begin
			axi_wr(`PFC_OFF_PAD5, 32'h181 | (m << 3));
			chk("pull mode", {pctl[3].pull_up, pctl[3].pull_down, pctl[3].repeater}, {m == 2, m == 1, m == 3});
		end
		// short pulses on an analog pad and the open-drain pad, with and without the filter
		pin <= 11'h7FF;
		axi_wr(`PFC_OFF_PAD10, 32'h091);
		repeat (10) @(posedge sys_clk);
		glitch(5, 1, low);
		chk("an filtered", low, 0);
		axi_wr(`PFC_OFF_PAD10, 32'h191);
		repeat (10) @(posedge sys_clk);
		glitch(5, 1, low);
		chk("an bypassed", low, 1);
		axi_wr(`PFC_OFF_PAD3, 32'h000);
		repeat (10) @(posedge sys_clk);
		chk("i2c features", pctl[1].i2c_features_en, 1);
		glitch(1, 2, low);
		chk("filtered", low, 0);
		axi_wr(`PFC_OFF_PAD3, 32'h100);
		repeat (10) @(posedge sys_clk);
		glitch(1, 2, low);
		chk("bypassed", low, 1);
		wrap_up();
	end
endmodule
`default_nettype wire
